// *** shared/blcfr_pkg.sv ***
// What this block does
// [R1] Sample-rate code 00/01/1X picks 800k/4M/24M; polarity bit, default high
// [R2] Hysteresis code 0..6 gives that many steps, default 4; code 7 refused
// [R3] Filter code 00 none, 01/10/11 reject 100/150/200 ns, default 11
// [R4] Frequency bit 0=500k 1=1M; shift bit 0=-12 percent, 1=none; both default 1
// [R5] Boost bits 3:2 overvoltage 17..38 V, bits 1:0 limit 750..1500 mA
// [R6] Upper threshold compares brightness top eight bits, 500k/1M switch, resets 0
// [R7] Lower threshold compares brightness top eight bits, 250k/500k switch, resets 0
// [R8] Low brightness register holds code bits 2:0, resets 111, rest reserved
// [R9] High brightness register holds code bits 10:3, resets all ones
// [R10] Shutdown-disable bit 0 forces shutdown when its flag sets; 1 only reports
// [R11] Fault control bit 3 enables short detection, resets 0, bits 7:4 reserved
// [R12] Status bits 4..0 report open, short, thermal, current limit, overvoltage
// [R13] Reserved bits and unmapped registers read as zero
// [R14] After fault shutdown, re-enable is refused until status has been read
// [R15] Serial write: byte after address selects register, next byte is data
// [R16] Higher frequency chosen when brightness top bits exceed the threshold
// [R17] Fault flag stays set until the status register is read
package blcfr_pkg;
  localparam logic [7:0] REG_PWM    = 8'h12;
  localparam logic [7:0] REG_BOOST  = 8'h13;
  localparam logic [7:0] REG_AF_HI  = 8'h15;
  localparam logic [7:0] REG_AF_LO  = 8'h16;
  localparam logic [7:0] REG_BR_LO  = 8'h18;
  localparam logic [7:0] REG_BR_HI  = 8'h19;
  localparam logic [7:0] REG_FCTL   = 8'h1e;
  localparam logic [7:0] REG_FSTAT  = 8'h1f;
  localparam logic [7:0] RST_PWM    = 8'hb3;
  localparam logic [6:0] RST_BOOST  = 7'h6f;
  localparam logic [7:0] RST_AF     = 8'h00;
  localparam logic [2:0] RST_BR_LO  = 3'h7;
  localparam logic [7:0] RST_BR_HI  = 8'hff;
  localparam logic [3:0] RST_FCTL   = 4'h7;
  localparam int PWM_RATE_LSB  = 6;
  localparam int PWM_POL_BIT   = 5;
  localparam int PWM_HYST_LSB  = 2;
  localparam int PWM_FILT_LSB  = 0;
  localparam int BST_SHIFT_BIT = 6;
  localparam int BST_FSEL_BIT  = 5;
  localparam int BST_IND_BIT   = 4;
  localparam int BST_OVG_LSB   = 2;
  localparam int BST_ILIM_LSB  = 0;
  localparam int FC_SHORT_BIT  = 3;
  localparam int FC_THERM_BIT  = 2;
  localparam int FC_ILIM_BIT   = 1;
  localparam int FC_OVG_BIT    = 0;
  localparam int FF_OPEN       = 4;
  localparam int FF_SHORT      = 3;
  localparam int FF_THERM      = 2;
  localparam int FF_ILIM       = 1;
  localparam int FF_OVG        = 0;
  localparam logic [2:0] HYST_BAD = 3'h7;
  localparam logic [6:0] I2C_ADDR_BASE = 7'h36;
  typedef enum logic [1:0] {
    AF_250  = 2'h0,
    AF_500  = 2'h1,
    AF_1000 = 2'h2
  } blcfr_afreq_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_REG  = 3'h2,
    ST_WDAT = 3'h3,
    ST_RDAT = 3'h4,
    ST_ACK  = 3'h5,
    ST_RACK = 3'h6
  } blcfr_st_t;
endpackage

// *** core/blcfr_pin_sync.sv ***
`timescale 1ns/1ps
module blcfr_pin_sync #(
  parameter int         W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit changes once the second and third stage agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= RST;
    end else begin
      q <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
    end
  end
endmodule

// *** core/blcfr_fault_latch.sv ***
`timescale 1ns/1ps
module blcfr_fault_latch (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [4:0] fault_s,
  input  wire logic       short_en,
  input  wire logic [2:0] sd_dis,
  input  wire logic       status_rd,
  output logic      [4:0] flags,
  output logic            shutdown
);
  logic [4:0] set_v;
  logic       sd_set;

  always_comb begin
    set_v = fault_s;
    set_v[blcfr_pkg::FF_SHORT] = fault_s[blcfr_pkg::FF_SHORT] & short_en; // [R11]
  end

  // Flags other than short whose shutdown is not disabled force shutdown
  assign sd_set = (set_v[blcfr_pkg::FF_THERM] & ~sd_dis[blcfr_pkg::FC_THERM_BIT])
                | (set_v[blcfr_pkg::FF_ILIM] & ~sd_dis[blcfr_pkg::FC_ILIM_BIT])
                | ((set_v[blcfr_pkg::FF_OVG] | set_v[blcfr_pkg::FF_OPEN])
                   & ~sd_dis[blcfr_pkg::FC_OVG_BIT]); // [R10]

  // Set wins over the clear from a status read
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags <= 5'h00;
    end else begin
      flags <= (flags & {5{~status_rd}}) | set_v; // [R12] [R17]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shutdown <= 1'b0;
    end else begin
      shutdown <= sd_set | (shutdown & ~status_rd); // [R10] [R14]
    end
  end
endmodule

// *** core/blcfr_regs.sv ***
`timescale 1ns/1ps
module blcfr_regs #(
  parameter logic [6:0] ADDR_BASE = blcfr_pkg::I2C_ADDR_BASE
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        addr_sel_i,
  input  wire logic        enable_req,
  input  wire logic        led_open_raw,
  input  wire logic        led_short_raw,
  input  wire logic        thermal_shutdown_raw,
  input  wire logic        switch_current_limit_raw,
  input  wire logic        output_overvoltage_guard_raw,
  output logic      [1:0]  pwm_rate,
  output logic             pwm_active_high,
  output logic      [2:0]  pwm_hyst,
  output logic      [1:0]  pwm_filt,
  output logic             boost_fsel_1m,
  output logic             boost_no_shift,
  output logic             boost_ind_10u,
  output logic      [1:0]  overvoltage_thr,
  output logic      [1:0]  current_limit_thr,
  output logic      [1:0]  afreq_sel,
  output logic      [10:0] bright_code,
  output logic             short_det_en,
  output logic      [4:0]  fault_flags,
  output logic             shutdown,
  output logic             device_active
);
  logic [7:0]  pin_q;
  logic        scl_s;
  logic        sda_s;
  logic        asel_s;
  logic [4:0]  fault_s;
  logic        scl_q_r;
  logic        sda_q_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [6:0]  my_addr;
  blcfr_pkg::blcfr_st_t st_r;
  blcfr_pkg::blcfr_st_t ret_r;
  logic [7:0]  sh_r;
  logic [3:0]  cnt_r;
  logic [7:0]  ptr_r;
  logic        oe_r;
  logic        mack_r;
  logic        byte_done;
  logic        wr_en;
  logic        load;
  logic [7:0]  ld_ptr;
  logic [7:0]  ld_byte;
  logic        status_rd;
  logic [7:0]  pwm_r;
  logic [6:0]  boost_r;
  logic [7:0]  af_hi_r;
  logic [7:0]  af_lo_r;
  logic [2:0]  br_lo_r;
  logic [7:0]  br_hi_r;
  logic [3:0]  fctl_r;
  blcfr_pkg::blcfr_afreq_t af_r;
  logic        active_r;

  blcfr_pin_sync #(
    .W   (8),
    .RST (8'h03)
  ) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       ({led_open_raw, led_short_raw, thermal_shutdown_raw, switch_current_limit_raw,
               output_overvoltage_guard_raw, addr_sel_i, sda_i, scl_i}),
    .q       (pin_q)
  );

  assign scl_s   = pin_q[0];
  assign sda_s   = pin_q[1];
  assign asel_s  = pin_q[2];
  assign fault_s = pin_q[7:3];
  assign my_addr = {ADDR_BASE[6:1], asel_s};

  // Read view of the bank
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] pwm,
                                         input logic [6:0] bst, input logic [7:0] ahi,
                                         input logic [7:0] alo, input logic [2:0] blo,
                                         input logic [7:0] bhi, input logic [3:0] fc,
                                         input logic [4:0] ff);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      blcfr_pkg::REG_PWM:   v = pwm;
      blcfr_pkg::REG_BOOST: v = {1'b0, bst};
      blcfr_pkg::REG_AF_HI: v = ahi;
      blcfr_pkg::REG_AF_LO: v = alo;
      blcfr_pkg::REG_BR_LO: v = {5'h00, blo};
      blcfr_pkg::REG_BR_HI: v = bhi;
      blcfr_pkg::REG_FCTL:  v = {4'h0, fc};
      blcfr_pkg::REG_FSTAT: v = {3'h0, ff};
      default:              v = 8'h00;
    endcase
    return v; // [R13]
  endfunction

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q_r;
  assign scl_fall  = ~scl_s & scl_q_r;
  assign start_c   = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_c    = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign byte_done = scl_fall && (cnt_r == 4'h8);
  assign wr_en     = byte_done && (st_r == blcfr_pkg::ST_WDAT); // [R15]
  assign load      = scl_fall && ((st_r == blcfr_pkg::ST_ACK && ret_r == blcfr_pkg::ST_RDAT) ||
                                  (st_r == blcfr_pkg::ST_RACK && mack_r));
  assign ld_ptr    = (st_r == blcfr_pkg::ST_RACK) ? ptr_r + 8'h01 : ptr_r;
  assign ld_byte   = rd_byte(ld_ptr, pwm_r, boost_r, af_hi_r, af_lo_r, br_lo_r, br_hi_r,
                             fctl_r, fault_flags);
  assign status_rd = load && (ld_ptr == blcfr_pkg::REG_FSTAT); // [R17]

  // Serial slave: sample on rising clock, drive on falling clock
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r   <= blcfr_pkg::ST_IDLE;
      ret_r  <= blcfr_pkg::ST_IDLE;
      sh_r   <= 8'h00;
      cnt_r  <= 4'h0;
      ptr_r  <= 8'h00;
      oe_r   <= 1'b0;
      mack_r <= 1'b0;
    end else if (start_c) begin
      st_r  <= blcfr_pkg::ST_ADDR;
      cnt_r <= 4'h0;
      oe_r  <= 1'b0;
    end else if (stop_c) begin
      st_r <= blcfr_pkg::ST_IDLE;
      oe_r <= 1'b0;
    end else begin
      unique case (st_r)
        blcfr_pkg::ST_IDLE: begin
          oe_r <= 1'b0;
        end
        blcfr_pkg::ST_ADDR, blcfr_pkg::ST_REG, blcfr_pkg::ST_WDAT: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_done) begin
            st_r <= blcfr_pkg::ST_ACK;
            oe_r <= 1'b1;
            if (st_r == blcfr_pkg::ST_ADDR) begin
              if (sh_r[7:1] == my_addr) begin
                ret_r <= sh_r[0] ? blcfr_pkg::ST_RDAT : blcfr_pkg::ST_REG;
              end else begin
                st_r <= blcfr_pkg::ST_IDLE;
                oe_r <= 1'b0;
              end
            end else if (st_r == blcfr_pkg::ST_REG) begin
              ptr_r <= sh_r; // [R15]
              ret_r <= blcfr_pkg::ST_WDAT;
            end else begin
              ptr_r <= ptr_r + 8'h01;
              ret_r <= blcfr_pkg::ST_WDAT;
            end
          end
        end
        blcfr_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            st_r  <= ret_r;
            if (ret_r == blcfr_pkg::ST_RDAT) begin
              sh_r <= ld_byte;
              oe_r <= ~ld_byte[7];
            end else begin
              oe_r <= 1'b0;
            end
          end
        end
        blcfr_pkg::ST_RDAT: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_done) begin
            st_r <= blcfr_pkg::ST_RACK;
            oe_r <= 1'b0;
          end else if (scl_fall) begin
            sh_r <= {sh_r[6:0], 1'b0};
            oe_r <= ~sh_r[6];
          end
        end
        blcfr_pkg::ST_RACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_s;
          end else if (scl_fall) begin
            cnt_r <= 4'h0;
            if (mack_r) begin
              st_r  <= blcfr_pkg::ST_RDAT;
              ptr_r <= ld_ptr;
              sh_r  <= ld_byte;
              oe_r  <= ~ld_byte[7];
            end else begin
              st_r <= blcfr_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          st_r <= blcfr_pkg::ST_IDLE;
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = oe_r;

  // Register writes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwm_r   <= blcfr_pkg::RST_PWM;
      boost_r <= blcfr_pkg::RST_BOOST;
      af_hi_r <= blcfr_pkg::RST_AF;
      af_lo_r <= blcfr_pkg::RST_AF;
      br_lo_r <= blcfr_pkg::RST_BR_LO;
      br_hi_r <= blcfr_pkg::RST_BR_HI;
      fctl_r  <= blcfr_pkg::RST_FCTL;
    end else if (wr_en) begin
      unique case (ptr_r)
        blcfr_pkg::REG_PWM: begin
          pwm_r[7:5] <= sh_r[7:5]; // [R1]
          pwm_r[1:0] <= sh_r[1:0]; // [R3]
          if (sh_r[blcfr_pkg::PWM_HYST_LSB +: 3] != blcfr_pkg::HYST_BAD) begin
            pwm_r[blcfr_pkg::PWM_HYST_LSB +: 3] <= sh_r[blcfr_pkg::PWM_HYST_LSB +: 3]; // [R2]
          end
        end
        blcfr_pkg::REG_BOOST: boost_r <= sh_r[6:0]; // [R4] [R5]
        blcfr_pkg::REG_AF_HI: af_hi_r <= sh_r; // [R6]
        blcfr_pkg::REG_AF_LO: af_lo_r <= sh_r; // [R7]
        blcfr_pkg::REG_BR_LO: br_lo_r <= sh_r[2:0]; // [R8]
        blcfr_pkg::REG_BR_HI: br_hi_r <= sh_r; // [R9]
        blcfr_pkg::REG_FCTL:  fctl_r  <= sh_r[3:0]; // [R10] [R11]
        default: ;
      endcase
    end
  end

  assign pwm_rate          = pwm_r[blcfr_pkg::PWM_RATE_LSB +: 2]; // [R1]
  assign pwm_active_high   = pwm_r[blcfr_pkg::PWM_POL_BIT]; // [R1]
  assign pwm_hyst          = pwm_r[blcfr_pkg::PWM_HYST_LSB +: 3]; // [R2]
  assign pwm_filt          = pwm_r[blcfr_pkg::PWM_FILT_LSB +: 2]; // [R3]
  assign boost_no_shift    = boost_r[blcfr_pkg::BST_SHIFT_BIT]; // [R4]
  assign boost_fsel_1m     = boost_r[blcfr_pkg::BST_FSEL_BIT]; // [R4]
  assign boost_ind_10u     = boost_r[blcfr_pkg::BST_IND_BIT];
  assign overvoltage_thr   = boost_r[blcfr_pkg::BST_OVG_LSB +: 2]; // [R5]
  assign current_limit_thr = boost_r[blcfr_pkg::BST_ILIM_LSB +: 2]; // [R5]
  assign bright_code       = {br_hi_r, br_lo_r}; // [R8] [R9]
  assign short_det_en      = fctl_r[blcfr_pkg::FC_SHORT_BIT]; // [R11]
  assign afreq_sel         = af_r;
  assign device_active     = active_r;

  // Auto-frequency choice from the top eight brightness bits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      af_r <= blcfr_pkg::AF_1000;
    end else if (br_hi_r > af_hi_r) begin
      af_r <= blcfr_pkg::AF_1000; // [R6] [R16]
    end else if (br_hi_r > af_lo_r) begin
      af_r <= blcfr_pkg::AF_500; // [R7] [R16]
    end else begin
      af_r <= blcfr_pkg::AF_250; // [R7]
    end
  end

  blcfr_fault_latch u_fault (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .fault_s   (fault_s),
    .short_en  (fctl_r[blcfr_pkg::FC_SHORT_BIT]),
    .sd_dis    (fctl_r[2:0]),
    .status_rd (status_rd),
    .flags     (fault_flags),
    .shutdown  (shutdown)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      active_r <= 1'b0;
    end else begin
      active_r <= enable_req & ~shutdown; // [R14]
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_wr_commit;
    wr_en ##1 1'b1;
  endsequence

  sequence s_quiet2;
    !status_rd [*2];
  endsequence

  flag_sticky_a: assert property (!status_rd |=> ((fault_flags & $past(fault_flags)) == $past(fault_flags))) // [R17]
    else $error("fault flag dropped without a status read");
  sd_hold_a: assert property (shutdown && !status_rd |=> shutdown) // [R14]
    else $error("shutdown released without a status read");
  sd_block_a: assert property (shutdown ##0 s_quiet2 |-> !device_active) // [R14]
    else $error("device active during fault shutdown");
  therm_sd_a: assert property (fault_s[blcfr_pkg::FF_THERM] && !fctl_r[blcfr_pkg::FC_THERM_BIT]
                               |=> shutdown && fault_flags[blcfr_pkg::FF_THERM]) // [R10]
    else $error("thermal fault did not force shutdown");
  report_only_a: assert property (!shutdown && fctl_r[2:0] == 3'h7 && fctl_r == $past(fctl_r)
                                  |=> !shutdown) // [R10]
    else $error("shutdown with all shutdowns disabled");
  short_gate_a: assert property (!fctl_r[blcfr_pkg::FC_SHORT_BIT] |=> !$rose(fault_flags[blcfr_pkg::FF_SHORT])) // [R11]
    else $error("short flag set with detection disabled");
  af_high_a: assert property ((br_hi_r > af_hi_r) |=> af_r == blcfr_pkg::AF_1000) // [R6] [R16]
    else $error("auto frequency not high above upper threshold");
  af_low_a: assert property ((br_hi_r <= af_hi_r) && (br_hi_r <= af_lo_r) |=> af_r == blcfr_pkg::AF_250) // [R7]
    else $error("auto frequency not low under both thresholds");
  hyst_valid_a: assert property (pwm_hyst != blcfr_pkg::HYST_BAD) // [R2]
    else $error("hysteresis holds the invalid code");
  wr_hi_a: assert property (wr_en && ptr_r == blcfr_pkg::REG_BR_HI |=> br_hi_r == $past(sh_r)) // [R9] [R15]
    else $error("high brightness write not stored");
  wr_lo_a: assert property (wr_en && ptr_r == blcfr_pkg::REG_BR_LO ##0 s_wr_commit
                            |-> {5'h00, bright_code[2:0]} == ($past(sh_r) & 8'h07)) // [R8] [R15]
    else $error("low brightness write not stored");
  rsvd_zero_a: assert property (load && ld_ptr == blcfr_pkg::REG_BR_LO |=> sh_r[7:3] == 5'h00) // [R13]
    else $error("reserved bits read as nonzero");
endmodule

// *** verif/blcfr_host_model.sv ***
`timescale 1ns/1ps
module blcfr_host_model (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  localparam int HALF = 8;
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(negedge clk_sys);
  endtask
  // Start or repeated start: data falls while clock is high
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // Data only changes while clock is low
  task automatic wbit(input logic b);
    sda_low = ~b;
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic rbit(output logic b);
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    repeat (HALF / 2) @(negedge clk_sys);
    b = sda;
    repeat (HALF / 2) @(negedge clk_sys);
    scl = 1'b0;
    half();
  endtask
  // Byte out MSB first, then sample acknowledge
  task automatic wbyte(input logic [7:0] d, output logic a);
    logic b;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(b);
    a = ~b;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(last);
  endtask
  // Address, register pointer, then data byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    wbyte({dev, 1'b0}, a0);
    wbyte(r, a1);
    wbyte(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] r, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    wbyte({dev, 1'b0}, a0);
    wbyte(r, a1);
    start();
    wbyte({dev, 1'b1}, a2);
    rbyte(d, 1'b1);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// *** verif/blcfr_regs_tb.sv ***
`timescale 1ns/1ps
module blcfr_regs_tb;
  localparam int LIMIT = 90000;
  logic        clk_sys, rstn, scl, host_low, sda_line, sda_o, sda_oe, addr_sel, enable_req;
  logic [4:0]  fault_raw, fault_flags;
  logic [1:0]  pwm_rate, pwm_filt, overvoltage_thr, current_limit_thr, afreq_sel;
  logic [2:0]  pwm_hyst;
  logic        pwm_active_high, boost_fsel_1m, boost_no_shift, boost_ind_10u, short_det_en, shutdown, device_active;
  logic [10:0] bright_code;
  logic [6:0]  dev;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;
  assign sda_line = ~(host_low | sda_oe);
  assign dev      = {blcfr_pkg::I2C_ADDR_BASE[6:1], addr_sel};
  logic [15:0] pwm_v, boost_v;
  assign pwm_v    = {8'h0, pwm_rate, pwm_active_high, pwm_hyst, pwm_filt};
  assign boost_v  = {9'h0, boost_no_shift, boost_fsel_1m, boost_ind_10u, overvoltage_thr, current_limit_thr};
  blcfr_host_model i_host (.clk_sys(clk_sys), .sda(sda_line), .scl(scl), .sda_low(host_low));
  blcfr_regs i_blcfr_regs (
    .clk_sys(clk_sys), .rstn(rstn), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_sel_i(addr_sel), .enable_req(enable_req), .led_open_raw(fault_raw[4]), .led_short_raw(fault_raw[3]),
    .thermal_shutdown_raw(fault_raw[2]), .switch_current_limit_raw(fault_raw[1]),
    .output_overvoltage_guard_raw(fault_raw[0]), .pwm_rate(pwm_rate), .pwm_active_high(pwm_active_high),
    .pwm_hyst(pwm_hyst), .pwm_filt(pwm_filt), .boost_fsel_1m(boost_fsel_1m), .boost_no_shift(boost_no_shift),
    .boost_ind_10u(boost_ind_10u), .overvoltage_thr(overvoltage_thr), .current_limit_thr(current_limit_thr),
    .afreq_sel(afreq_sel), .bright_code(bright_code), .short_det_en(short_det_en), .fault_flags(fault_flags),
    .shutdown(shutdown), .device_active(device_active)
  );
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic summarize();
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      summarize();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    logic ok;
    i_host.write_reg(dev, r, d, ok);
    check(16'(ok), 16'h1);
  endtask
  task automatic rd(input logic [7:0] r, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_host.read_reg(dev, r, d, ok);
    check({7'h0, ok, d}, {8'h1, exp});
  endtask
  task automatic test_defaults();
    logic [7:0] a [8] = '{8'h12, 8'h13, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1e, 8'h1f};
    logic [7:0] v [8] = '{8'hb3, 8'h6f, 8'h00, 8'h00, 8'h07, 8'hff, 8'h07, 8'h00};
    check(pwm_v, 16'h00b3);
    check(boost_v, 16'h006f);
    check(16'(bright_code), 16'h07ff);
    check(16'({short_det_en, fault_flags, shutdown, device_active}), 16'h0);
    check(16'(afreq_sel), 16'h2);
    check(16'({sda_o, sda_oe}), 16'h0);
    for (int i = 0; i < 8; i++) rd(a[i], v[i]);
    rd(8'h14, 8'h00);
  endtask
  task automatic test_pwm();
    logic [7:0] v [8] = '{8'h00, 8'h45, 8'hae, 8'hf3, 8'h55, 8'h1a, 8'h4b, 8'h9c};
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      e = (v[i][4:2] == 3'h7) ? {v[i][7:5], e[4:2], v[i][1:0]} : v[i];
      wr(8'h12, v[i]);
      rd(8'h12, e);
      check(pwm_v, 16'(e));
    end
  endtask
  task automatic test_boost();
    logic [7:0] v [4] = '{8'hff, 8'h00, 8'h96, 8'h29};
    for (int i = 0; i < 4; i++) begin
      wr(8'h13, v[i]);
      rd(8'h13, v[i] & 8'h7f);
      check(boost_v, 16'(v[i][6:0]));
    end
  endtask
  task automatic test_bright();
    logic [7:0] h [5] = '{8'h81, 8'h80, 8'h41, 8'h40, 8'h00};
    logic [1:0] f [5] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
    wr(8'h15, 8'h80);
    wr(8'h16, 8'h40);
    rd(8'h15, 8'h80);
    rd(8'h16, 8'h40);
    wr(8'h18, 8'hfd);
    rd(8'h18, 8'h05);
    for (int i = 0; i < 5; i++) begin
      wr(8'h19, h[i]);
      rd(8'h19, h[i]);
      check(16'(bright_code), {5'h0, h[i], 3'h5});
      check(16'(afreq_sel), 16'(f[i]));
    end
  endtask
  task automatic test_faults();
    logic [7:0] fc [2] = '{8'h0f, 8'h08};
    logic       sd;
    enable_req = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(8'h1e, fc[k] | 8'hf0);
      rd(8'h1e, fc[k]);
      check(16'(short_det_en), 16'h1);
      for (int i = 0; i < 5; i++) begin
        sd = (i != 3) && !fc[k][(i == 4) ? 0 : i];
        fault_raw = 5'(1 << i);
        repeat (20) @(negedge clk_sys);
        check({fault_flags, shutdown, device_active}, {9'h0, 5'(1 << i), sd, ~sd});
        fault_raw = 5'h0;
        repeat (20) @(negedge clk_sys);
        check({fault_flags, shutdown, device_active}, {9'h0, 5'(1 << i), sd, ~sd});
        rd(8'h1f, 8'(1 << i));
        repeat (4) @(negedge clk_sys);
        check({fault_flags, shutdown, device_active}, 16'h1);
      end
    end
    wr(8'h1e, 8'h07);
    fault_raw = 5'h08;
    repeat (20) @(negedge clk_sys);
    check(16'({short_det_en, fault_flags}), 16'h0);
    fault_raw = 5'h0;
  endtask
  task automatic test_addr();
    logic ok;
    addr_sel = 1'b1;
    repeat (8) @(negedge clk_sys);
    wr(8'h15, 8'h3c);
    i_host.write_reg({blcfr_pkg::I2C_ADDR_BASE[6:1], 1'b0}, 8'h15, 8'h11, ok);
    check(16'(ok), 16'h0);
    rd(8'h15, 8'h3c);
  endtask
  initial begin
    rstn       = 1'b0;
    addr_sel   = 1'b0;
    enable_req = 1'b0;
    fault_raw  = 5'h0;
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (6) @(negedge clk_sys);
    test_defaults();
    test_pwm();
    test_boost();
    test_bright();
    test_faults();
    test_addr();
    summarize();
  end
endmodule
